// file: cis_sequencer.sv
// interrupt entry, return and global enable sequencing for the core
`timescale 1ns/1ps
`default_nettype none
module cis_sequencer (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire cis_pkg::cis_core_type          core,
  input  wire logic [cis_pkg::N_SRC-1:0]      src_event,
  input  wire logic [cis_pkg::N_SRC-1:0]      src_enable,
  input  wire logic [cis_pkg::N_SRC-1:0]      src_is_level,
  input  wire logic [cis_pkg::N_SRC-1:0]      flag_wr_one,
  input  wire logic                           flags_wr,
  input  wire logic [cis_pkg::FLAGS_W-1:0]    flags_wdata,
  output cis_pkg::cis_ctl_type                ctl,
  output logic [cis_pkg::FLAGS_W-1:0]         core_flags_register,
  output logic [cis_pkg::N_SRC-1:0]           irq_flags,
  output logic [cis_pkg::SP_W-1:0]            stack_ptr,
  output logic [cis_pkg::PC_W-1:0]            push_addr,
  output logic                                in_sequence
);
  typedef enum logic [1:0] {
    CIS_RUN,
    CIS_WAKE,
    CIS_ENTRY,
    CIS_RETURN
  } cis_state_type;

  // ************************************************************
  // state
  // ************************************************************
  cis_state_type               state_r, state_nxt;
  logic [2:0]                  cnt_r, cnt_nxt;
  logic [cis_pkg::FLAGS_W-1:0] flags_r, flags_nxt;
  logic [cis_pkg::N_SRC-1:0]   flag_r, flag_nxt;
  logic [cis_pkg::SP_W-1:0]    sp_r, sp_nxt;
  logic [cis_pkg::PC_W-1:0]    ret_r, ret_nxt;
  logic [cis_pkg::PC_W-1:0]    vec_r, vec_nxt;
  logic [2:0]                  win_r, win_nxt;
  logic                        hold_r, hold_nxt;

  // ************************************************************
  // request decode
  // ************************************************************
  logic [cis_pkg::N_SRC-1:0] raw_req;
  logic [cis_pkg::N_SRC-1:0] live_req;
  logic                      req_any;
  logic [2:0]                req_idx;
  logic                      gie;
  logic                      may_take;
  logic                      take;
  logic                      at_bound;
  logic                      last_cycle;
  logic [cis_pkg::N_SRC-1:0] served_clr;

  genvar s;
  generate
    for (s = 0; s < cis_pkg::N_SRC; s++) begin : g_src
      // level sources bypass the latch and vanish with their cause
      assign raw_req[s] = src_is_level[s] ? src_event[s]
                                          : flag_r[s];
      assign live_req[s] = raw_req[s] & src_enable[s];
      assign served_clr[s] = take && (req_idx == 3'(s))
                             && !src_is_level[s];
      // a new event beats a clear in the same cycle
      assign flag_nxt[s] = (src_event[s] && !src_is_level[s])
                           || (flag_r[s] && !flag_wr_one[s]
                               && !served_clr[s]);
    end
  endgenerate

  cis_arbiter u_arb (
    .req (live_req),
    .any (req_any),
    .idx (req_idx)
  );

  assign gie = flags_r[cis_pkg::GIE_BIT];
  // disable in this cycle blocks acceptance at once
  assign may_take = gie && !core.global_disable_instr
                    && !hold_r;
  assign at_bound = core.boundary || core.sleeping;
  assign take = (state_r == CIS_RUN) && at_bound && may_take
                && req_any;
  assign last_cycle = (cnt_r == 3'h0);

  // ************************************************************
  // named decodes
  // ************************************************************
  logic                      ret_accept;
  logic                      wake_take;
  logic [cis_pkg::PC_W-1:0]  vec_pick;
  logic                      seq_busy;
  logic                      ret_ends;
  // a return only counts when the instruction really retires
  assign ret_accept = core.return_from_irq_instr && core.boundary;
  // a sleeping core has no boundary but must still be woken
  assign wake_take  = take && core.sleeping;
  // widen before adding so the top source cannot wrap to reset
  assign vec_pick   = cis_pkg::RESET_VECTOR
                      + cis_pkg::VECTOR_STRIDE
                      * (cis_pkg::PC_W'(req_idx) + 12'h001);
  assign seq_busy   = (state_r != CIS_RUN);
  // last return cycle: pointer comes back, enable goes up
  assign ret_ends   = (state_r == CIS_RETURN) && last_cycle;

  // ************************************************************
  // sequencing
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    flags_nxt = flags_r;
    sp_nxt    = sp_r;
    ret_nxt   = ret_r;
    vec_nxt   = vec_r;
    win_nxt   = win_r;
    hold_nxt  = hold_r;
    // software owns the whole flags register; never saved here
    if (flags_wr) begin
      flags_nxt = flags_wdata;
    end
    if (core.boundary) begin
      hold_nxt = 1'b0;
    end
    if (core.global_disable_instr) begin
      flags_nxt[cis_pkg::GIE_BIT] = 1'b0;
    end
    if (core.global_enable_instr) begin
      flags_nxt[cis_pkg::GIE_BIT] = 1'b1;
      hold_nxt = 1'b1;
    end
    unique case (state_r)
      CIS_RUN: begin
        if (take) begin
          flags_nxt[cis_pkg::GIE_BIT] = 1'b0;
          win_nxt = req_idx;
          ret_nxt = core.next_pc;
          vec_nxt = vec_pick;
          if (wake_take) begin
            state_nxt = CIS_WAKE;
            cnt_nxt   = cis_pkg::WAKE_CNT;
          end else begin
            state_nxt = CIS_ENTRY;
            cnt_nxt   = cis_pkg::ENTRY_CNT;
          end
        end else if (ret_accept) begin
          state_nxt = CIS_RETURN;
          cnt_nxt   = cis_pkg::RETURN_CNT;
        end
      end
      CIS_WAKE: begin
        cnt_nxt = cnt_r - 3'h1;
        if (last_cycle) begin
          state_nxt = CIS_ENTRY;
          cnt_nxt   = cis_pkg::ENTRY_CNT;
        end
      end
      CIS_ENTRY: begin
        cnt_nxt = cnt_r - 3'h1;
        if (last_cycle) begin
          state_nxt = CIS_RUN;
          sp_nxt    = sp_r - cis_pkg::RET_BYTES;
        end
      end
      CIS_RETURN: begin
        cnt_nxt = cnt_r - 3'h1;
        if (last_cycle) begin
          state_nxt = CIS_RUN;
          sp_nxt    = sp_r + cis_pkg::RET_BYTES;
          flags_nxt[cis_pkg::GIE_BIT] = 1'b1;
          hold_nxt  = 1'b1;
        end
      end
    endcase
  end

  // ************************************************************
  // registers (all on the single undivided core clock)
  // ************************************************************
  // sequence state and its cycle counter
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= CIS_RUN;
      cnt_r   <= 3'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // flags register, enable bit cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_r <= cis_pkg::FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // latched per-source flags
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // stack pointer, moved by two at push and pop
  always_ff @(posedge clk) begin
    if (rst) begin
      sp_r <= cis_pkg::SP_RST;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // captured return address, vector and winner
  always_ff @(posedge clk) begin
    if (rst) begin
      ret_r <= cis_pkg::RESET_VECTOR;
      vec_r <= cis_pkg::RESET_VECTOR;
      win_r <= 3'h0;
    end else begin
      ret_r <= ret_nxt;
      vec_r <= vec_nxt;
      win_r <= win_nxt;
    end
  end

  // one-instruction hold after enable or return
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // ************************************************************
  // core control
  // ************************************************************
  logic entry_done;
  assign entry_done = (state_r == CIS_ENTRY) && last_cycle;
  // pc load happens as entry ends; the vector's own jump
  // then costs the core its normal three cycles
  assign ctl.stall   = seq_busy;
  assign ctl.push    = entry_done;
  assign ctl.pop     = ret_ends;
  assign ctl.load_pc = entry_done;
  assign ctl.pc      = vec_r;

  // ************************************************************
  // limitations
  // ************************************************************
  // a return that meets a take at the same boundary loses to
  // the take; handlers normally run with enable low, so this
  // only bites when software re-enables inside a handler
  // the wake path assumes sleeping stays high until entry starts
  // only one sequence runs at a time; nesting comes from
  // software raising enable in a handler; after the enable instruction the hold
  // blocks one boundary, and the boundary after it may start a fresh entry on top of it
  // the winner index is kept but drives no output; the vector
  // already carries everything the core needs
  // the whole flags register is software's; only bit 7 is
  // touched by this block, so the other bits pass unchanged

  // ************************************************************
  // observed state
  // ************************************************************
  assign core_flags_register = flags_r;
  assign irq_flags           = flag_r;
  assign stack_ptr           = sp_r;
  assign push_addr           = ret_r;
  assign in_sequence         = seq_busy;
endmodule
`default_nettype wire

// file: cis_pkg.sv
// shared constants and carrier types for the interrupt sequencer
package cis_pkg;
  localparam int unsigned N_SRC      = 8;
  localparam int unsigned PC_W       = 12;
  localparam int unsigned SP_W       = 16;
  localparam int unsigned FLAGS_W    = 8;
  localparam int unsigned GIE_BIT    = 7;
  localparam logic [5:0]  FLAGS_IO_ADDR = 6'h3F;
  localparam logic [FLAGS_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [PC_W-1:0] RESET_VECTOR = 12'h000;
  localparam logic [PC_W-1:0] VECTOR_STRIDE = 12'h001;
  localparam logic [SP_W-1:0] SP_RST = 16'h01FF;
  localparam logic [SP_W-1:0] RET_BYTES = 16'h0002;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned ENTRY_CYC   = 4;
  localparam int unsigned WAKE_CYC    = 4;
  localparam int unsigned RETURN_CYC  = 4;
  localparam int unsigned JUMP_CYC    = 3;
  localparam logic [2:0] ENTRY_CNT  = 3'(ENTRY_CYC - 1);
  localparam logic [2:0] WAKE_CNT   = 3'(WAKE_CYC - 1);
  localparam logic [2:0] RETURN_CNT = 3'(RETURN_CYC - 1);

  typedef enum logic [1:0] {
    CIS_SRC_FLAG  = 2'h0,
    CIS_SRC_LEVEL = 2'h1
  } cis_kind_type;

  // one instruction boundary report from the core pipeline
  typedef struct packed {
    logic            boundary;
    logic            global_disable_instr;
    logic            global_enable_instr;
    logic            return_from_irq_instr;
    logic            sleeping;
    logic [PC_W-1:0] next_pc;
  } cis_core_type;

  typedef struct packed {
    logic            stall;
    logic            push;
    logic            pop;
    logic            load_pc;
    logic [PC_W-1:0] pc;
  } cis_ctl_type;
endpackage

// file: cis_arbiter.sv
// fixed priority pick of the lowest-numbered requesting source
`timescale 1ns/1ps
`default_nettype none
module cis_arbiter (
  input  wire logic [cis_pkg::N_SRC-1:0] req,
  output logic                           any,
  output logic [2:0]                     idx
);
  logic [2:0] pick [cis_pkg::N_SRC:0];
  assign pick[cis_pkg::N_SRC] = 3'h0;
  genvar g;
  generate
    for (g = 0; g < cis_pkg::N_SRC; g++) begin : g_pri
      // lower index means lower vector, hence higher priority
      assign pick[g] = req[g] ? 3'(g) : pick[g+1];
    end
  endgenerate
  assign any = |req;
  assign idx = pick[0];
endmodule
`default_nettype wire

// file: cis_sequencer_props.sv
// port assertions for the interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module cis_sequencer_props (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire cis_pkg::cis_core_type    core,
  input wire logic [7:0]               src_event,
  input wire logic [7:0]               src_is_level,
  input wire cis_pkg::cis_ctl_type     ctl,
  input wire logic [7:0]               core_flags_register,
  input wire logic [7:0]               irq_flags,
  input wire logic [15:0]              stack_ptr,
  input wire logic                     in_sequence
);
  // ****
  // properties
  // ****
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  a_entry_four_cycles: assert property (($rose(ctl.stall) && !$past(core.return_from_irq_instr) && !$past(core.sleeping)) |-> !ctl.push [*3] ##1 ctl.push) else $error("entry push late");
  a_entry_gie_clear: assert property (($rose(ctl.stall) && !$past(core.return_from_irq_instr)) |-> !core_flags_register[7]) else $error("enable kept on entry");
  a_push_sp_down: assert property (ctl.push |=> stack_ptr == $past(stack_ptr) - 16'h0002) else $error("push sp wrong");
  a_pop_sp_up: assert property (ctl.pop |=> stack_ptr == $past(stack_ptr) + 16'h0002 && core_flags_register[7]) else $error("pop wrong");
  a_return_four: assert property ((core.return_from_irq_instr && core.boundary && !in_sequence) |=> (ctl.stall && !ctl.pop) [*3] ##1 (ctl.stall && ctl.pop)) else $error("return length");
  a_gie_zero_block: assert property ((!core_flags_register[7] && !core.return_from_irq_instr && !ctl.stall) |=> !ctl.stall) else $error("taken while disabled");
  a_disable_same_cycle: assert property ((core.global_disable_instr && !ctl.stall && !core.return_from_irq_instr) |=> !ctl.stall) else $error("taken at disable");
  a_enable_one_instr: assert property ((core.global_enable_instr && core.boundary && !ctl.stall) |=> !ctl.stall [*2]) else $error("taken after enable");
  a_return_one_instr: assert property (ctl.pop |=> !ctl.stall [*2]) else $error("taken after return");
  a_flag_latches: assert property ((src_event & ~src_is_level) != 8'h00 |=> $rose(ctl.stall) || (irq_flags & $past(src_event & ~src_is_level)) == $past(src_event & ~src_is_level)) else $error("flag lost");
endmodule
bind cis_sequencer cis_sequencer_props i_cis_sequencer_props (.clk(clk), .rst(rst), .core(core), .src_event(src_event), .src_is_level(src_is_level), .ctl(ctl), .core_flags_register(core_flags_register), .irq_flags(irq_flags), .stack_ptr(stack_ptr), .in_sequence(in_sequence));
`default_nettype wire

// file: cis_core_model.sv
// behavioural core pipeline facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module cis_core_model (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  run,
  input wire logic                  dis,
  input wire logic                  en,
  input wire logic                  ret,
  input wire cis_pkg::cis_ctl_type  ctl,
  output var cis_pkg::cis_core_type core
);
  // ****
  // single-cycle instructions
  // ****
  logic [11:0] pc_r;
  logic        bnd;
  // no boundary while stalled, so nothing ends mid-sequence
  assign bnd = run & ~ctl.stall;
  assign core = {bnd, dis & bnd, en & bnd, ret & bnd, 1'b0, pc_r};
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_r <= 12'h100;
    end else if (ctl.load_pc) begin
      pc_r <= ctl.pc + 12'h001;
    end else if (bnd) begin
      pc_r <= pc_r + 12'h001;
    end
  end
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for the interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst, run, dis, en, ret, flags_wr, got, in_sequence;
  logic [7:0] src_event, src_enable, src_is_level, flag_wr_one, flags_wdata;
  logic [7:0] core_flags_register, irq_flags;
  logic [11:0] p, push_addr;
  logic [15:0] stack_ptr;
  int err_total, check_count;
  cis_pkg::cis_core_type core;
  cis_pkg::cis_ctl_type  ctl;
  cis_sequencer i_cis_sequencer (.clk(clk), .rst(rst), .core(core),
    .src_event(src_event), .src_enable(src_enable),
    .src_is_level(src_is_level), .flag_wr_one(flag_wr_one),
    .flags_wr(flags_wr), .flags_wdata(flags_wdata), .ctl(ctl),
    .core_flags_register(core_flags_register), .irq_flags(irq_flags),
    .stack_ptr(stack_ptr), .push_addr(push_addr),
    .in_sequence(in_sequence));
  cis_core_model i_cis_core_model (.clk(clk), .rst(rst), .run(run),
    .dis(dis), .en(en), .ret(ret), .ctl(ctl), .core(core));
  // ****
  // tasks
  // ****
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // waits for push (sel 0) or pop (sel 1), bounded
  task automatic wait_on(input logic sel, must, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < 20 && !hit; i++) begin
      @(negedge clk);
      hit = ((sel ? ctl.pop : ctl.push) === 1'b1);
    end
    if (must && !hit) begin
      err_total++;
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] v);
    @(posedge clk);
    flags_wr <= 1'b1;
    flags_wdata <= v;
    @(posedge clk);
    flags_wr <= 1'b0;
  endtask
  task automatic clr(input logic [7:0] v);
    @(posedge clk);
    flag_wr_one <= v;
    @(posedge clk);
    flag_wr_one <= 8'h00;
    @(negedge clk);
  endtask
  task automatic ev(input logic [7:0] v);
    @(posedge clk);
    src_event <= v;
    @(posedge clk);
    src_event <= 8'h00;
  endtask
  task automatic do_ret();
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    wait_on(1'b1, 1'b1, got);
    @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ****
  // sequence
  // ****
  initial begin
    {rst, run, dis, en, ret, flags_wr} = 6'h20;
    {src_event, src_enable, src_is_level, flag_wr_one, flags_wdata} = '0;
    err_total = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("flags", core_flags_register, 8'h00);
    chk("sp", stack_ptr, 16'h01FF);
    ev(8'h04);
    @(negedge clk);
    chk("latched", irq_flags, 8'h04);
    clr(8'hFB);
    chk("kept", irq_flags, 8'h04);
    clr(8'h04);
    chk("cleared", irq_flags, 8'h00);
    ev(8'h24);
    src_enable <= 8'h24;
    wr(8'h80);
    p = core.next_pc;
    run <= 1'b1;
    wait_on(1'b0, 1'b1, got);
    chk("vector", ctl.pc, 12'h003);
    chk("ret addr", push_addr, p);
    chk("irqf", irq_flags, 8'h20);
    chk("gie", core_flags_register[7], 1'b0);
    chk("in seq", in_sequence, 1'b1);
    @(negedge clk);
    chk("sp push", stack_ptr, 16'h01FD);
    do_ret();
    chk("sp pop", stack_ptr, 16'h01FF);
    chk("gie", core_flags_register[7], 1'b1);
    wait_on(1'b0, 1'b1, got);
    chk("vector 2", ctl.pc, 12'h006);
    do_ret();
    wr(8'h00);
    {src_is_level, src_enable, src_event} <= 24'h010101;
    @(posedge clk);
    src_event <= 8'h00;
    wr(8'h80);
    wait_on(1'b0, 1'b0, got);
    chk("level gone", got, 1'b0);
    @(posedge clk);
    {src_event, dis} <= 9'h003;
    @(posedge clk);
    dis <= 1'b0;
    wait_on(1'b0, 1'b0, got);
    chk("at disable", got, 1'b0);
    @(posedge clk);
    en <= 1'b1;
    @(posedge clk);
    en <= 1'b0;
    wait_on(1'b0, 1'b1, got);
    chk("vector 0", ctl.pc, 12'h001);
    test_done();
  end
endmodule
`default_nettype wire
